// ---- verilog/pcie_err_map.svh ----
// constants of the user error reporting link: fields, codes, offsets
`ifndef PCIE_ERR_MAP_SVH
`define PCIE_ERR_MAP_SVH

// ----------------------------------------
// error indication bit positions
// ----------------------------------------
`define ERR_W          12
`define ERR_ECRC       0
`define ERR_UR         1
`define ERR_CPL_TO     2
`define ERR_CPL_UNEXP  3
`define ERR_CPL_ABORT  4
`define ERR_COR        5
`define ERR_ATOMIC_BLK 6
`define ERR_MC_BLK     7
`define ERR_COR_INT    8
`define ERR_MALFORMED  9
`define ERR_POISONED   10
`define ERR_UNCOR_INT  11

// ----------------------------------------
// power state and message codes
// ----------------------------------------
`define PWR_D0         2'h0
`define MSG_CODE_COR   8'h30
`define MSG_CODE_NF    8'h31
`define MSG_CODE_FATAL 8'h33

// ----------------------------------------
// user-end register offsets and fields
// ----------------------------------------
`define REG_CTRL       4'h0
`define REG_STAT       4'h1
`define REG_ERR        4'h2
`define REG_MSG        4'h3
`define CTRL_WAKE_EN   0
`define ERR_POSTED_BIT 12
`define STAT_PWR_LSB   12
`define STAT_PME_BIT   14
`define STAT_FREE_LSB  16
`define MSG_DATA_LSB   8
`define MSG_RCVD_BIT   24
`define MSG_NEW_BIT    31

`endif

// ---- verilog/pcie_err_pkg.sv ----
// types and shared helpers of the user error reporting link
`default_nettype none
`include "pcie_err_map.svh"

package pcie_err_pkg;

	typedef logic [`ERR_W-1:0] err_vec_t;

	typedef enum logic [1:0] {MSG_COR, MSG_NONFATAL, MSG_FATAL} msg_kind_t;

	typedef enum logic {CPL_UR, CPL_CA} cpl_status_t;

	// keep only the lowest set indication
	function automatic err_vec_t first_set(input err_vec_t v);
		return v & (~v + err_vec_t'(1));
	endfunction : first_set

endpackage : pcie_err_pkg

`default_nettype wire

// ---- verilog/pcie_err_if.sv ----
// link between the core end and the user application end
`timescale 1ns/1ps
`default_nettype none

interface pcie_err_if;
	import pcie_err_pkg::*;

	err_vec_t   err;
	logic       err_posted;
	logic       wake_request_pulse;
	logic [1:0] powerstate;
	logic       pme_en;
	logic       msg_valid;
	logic       msg_received;
	logic [7:0] msg_code;
	logic [15:0] msg_data;

	modport core (
		input  err, err_posted, wake_request_pulse,
		output powerstate, pme_en, msg_valid, msg_received, msg_code,
		       msg_data
	);

	modport user (
		output err, err_posted, wake_request_pulse,
		input  powerstate, pme_en, msg_valid, msg_received, msg_code,
		       msg_data
	);

endinterface : pcie_err_if

`default_nettype wire

// ---- verilog/pcie_err_core.sv ----
// core end: turns user error indications into link actions
`timescale 1ns/1ps
`default_nettype none
`include "pcie_err_map.svh"

module pcie_err_core #(
	parameter bit FORWARD_MSGS = 1'b0,
	parameter bit ROOT_PORT    = 1'b0
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// link to user application
	pcie_err_if.core                      e,
	// configuration space controls
	input  wire logic [1:0]               pwr_state,
	input  wire logic                     pme_enable,
	input  wire logic                     aer_en,
	input  wire logic                     cor_en,
	input  wire logic                     nf_en,
	input  wire logic                     fatal_en,
	input  wire logic                     serr_en,
	input  wire pcie_err_pkg::err_vec_t   aer_mask,
	input  wire pcie_err_pkg::err_vec_t   aer_sev,
	input  wire pcie_err_pkg::err_vec_t   status_clr,
	// received and internal events
	input  wire logic                     rx_msg_valid,
	input  wire logic [7:0]               rx_msg_code,
	input  wire logic [15:0]              rx_msg_data,
	input  wire logic                     int_err_valid,
	input  wire pcie_err_pkg::msg_kind_t  int_err_kind,
	// link side actions
	output logic                          tx_cpl_valid,
	output pcie_err_pkg::cpl_status_t     tx_cpl_status,
	output logic                          tx_msg_valid,
	output pcie_err_pkg::msg_kind_t       tx_msg_kind,
	output logic                          stream_msg_valid,
	output logic [7:0]                    stream_msg_code,
	// configuration status
	output pcie_err_pkg::err_vec_t        err_status,
	output logic                          pme_status
);
	import pcie_err_pkg::*;

	typedef struct packed {
		logic        msg_valid;
		logic        msg_rcvd;
		logic [7:0]  msg_code;
		logic [15:0] msg_data;
		logic        pend_valid;
		logic [7:0]  pend_code;
		logic        cpl_valid;
		cpl_status_t cpl_st;
		logic        tmsg_valid;
		msg_kind_t   tmsg_kind;
		logic        str_valid;
		logic [7:0]  str_code;
		err_vec_t    status;
		logic        pme;
	} core_state_t;

	core_state_t s_q, s_d;

	function automatic logic [7:0] kind_code(input msg_kind_t k);
		unique case (k)
			MSG_COR:      return `MSG_CODE_COR;
			MSG_NONFATAL: return `MSG_CODE_NF;
			MSG_FATAL:    return `MSG_CODE_FATAL;
			default:      return `MSG_CODE_FATAL;
		endcase
	endfunction : kind_code

	function automatic logic kind_enabled(input msg_kind_t k,
		input logic ce, input logic ne, input logic fe, input logic se);
		unique case (k)
			MSG_COR:      return ce;
			MSG_NONFATAL: return ne | se;
			default:      return fe | se;
		endcase
	endfunction : kind_enabled

	assign e.powerstate = pwr_state;
	assign e.pme_en     = pme_enable;

	always_comb begin
		err_vec_t  hit;
		logic      adv;
		logic      msg_do;
		msg_kind_t kind;
		logic      gen_do;
		msg_kind_t gen_k;
		hit    = first_set(e.err);
		adv    = |(hit & ((err_vec_t'(1) << `ERR_CPL_TO) |
		                  (err_vec_t'(1) << `ERR_CPL_UNEXP) |
		                  (err_vec_t'(1) << `ERR_ATOMIC_BLK) |
		                  (err_vec_t'(1) << `ERR_POISONED))) & ~e.err_posted;
		msg_do = 1'b0;
		kind   = MSG_NONFATAL;
		gen_do = 1'b0;
		gen_k  = MSG_COR;
		s_d    = s_q;
		s_d.cpl_valid  = 1'b0;
		s_d.tmsg_valid = 1'b0;
		s_d.str_valid  = 1'b0;
		s_d.msg_valid  = 1'b0;
		if (hit[`ERR_COR] | hit[`ERR_COR_INT]) begin
			msg_do = 1'b1;
			kind   = MSG_COR;
		end else if (hit[`ERR_UR] & ~e.err_posted) begin
			s_d.cpl_valid = 1'b1;
			s_d.cpl_st    = CPL_UR;
			msg_do        = aer_en;
			kind          = MSG_COR;
		end else if (hit[`ERR_CPL_ABORT] & ~e.err_posted) begin
			s_d.cpl_valid = 1'b1;
			s_d.cpl_st    = CPL_CA;
			msg_do        = 1'b1;
			kind          = aer_en ? MSG_COR : MSG_NONFATAL;
		end else if (adv) begin
			msg_do = aer_en;
			kind   = MSG_COR;
		end else if (|hit) begin
			msg_do = 1'b1;
			if (aer_en)
				kind = (|(hit & aer_sev)) ? MSG_FATAL : MSG_NONFATAL;
			else
				kind = hit[`ERR_MALFORMED] ? MSG_FATAL : MSG_NONFATAL;
		end
		msg_do = msg_do & kind_enabled(kind, cor_en, nf_en, fatal_en,
		                               serr_en) &
		         ~(aer_en & |(hit & aer_mask));
		gen_do = msg_do | int_err_valid;
		gen_k  = msg_do ? kind : int_err_kind;
		s_d.status = (s_q.status & ~status_clr) | hit;
		s_d.pme    = (s_q.pme & ~status_clr[0]) | e.wake_request_pulse;
		if (ROOT_PORT) begin
			if (gen_do) begin
				s_d.pend_valid = 1'b1;
				s_d.pend_code  = kind_code(gen_k);
			end
		end else begin
			s_d.tmsg_valid = gen_do;
			s_d.tmsg_kind  = gen_k;
		end
		if (rx_msg_valid) begin
			s_d.msg_valid = 1'b1;
			s_d.msg_rcvd  = 1'b1;
			s_d.msg_code  = rx_msg_code;
			s_d.msg_data  = rx_msg_data;
		end else if (s_q.pend_valid) begin
			s_d.msg_valid  = 1'b1;
			s_d.msg_rcvd   = 1'b0;
			s_d.msg_code   = s_q.pend_code;
			s_d.msg_data   = '0;
			s_d.pend_valid = ROOT_PORT & gen_do;
		end
		if (FORWARD_MSGS & rx_msg_valid) begin
			s_d.str_valid = 1'b1;
			s_d.str_code  = rx_msg_code;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign e.msg_valid       = s_q.msg_valid;
	assign e.msg_received    = s_q.msg_rcvd;
	assign e.msg_code        = s_q.msg_code;
	assign e.msg_data        = s_q.msg_data;
	assign tx_cpl_valid      = s_q.cpl_valid;
	assign tx_cpl_status     = s_q.cpl_st;
	assign tx_msg_valid      = s_q.tmsg_valid;
	assign tx_msg_kind       = s_q.tmsg_kind;
	assign stream_msg_valid  = s_q.str_valid;
	assign stream_msg_code   = s_q.str_code;
	assign err_status        = s_q.status;
	assign pme_status        = s_q.pme;

endmodule : pcie_err_core

`default_nettype wire

// ---- verilog/pcie_err_user.sv ----
// user application end: completions, tracking, error reporting
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pcie_err_map.svh"

module pcie_err_user #(
	parameter int TAGS      = 32,
	parameter int TAG_W     = 5,
	parameter int CPL_SPACE = 1024,
	parameter int CRED_W    = 16
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// link to core
	pcie_err_if.user                e,
	// register port
	input  wire logic [3:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [31:0]             reg_rdata,
	// inbound read requests and their completions
	input  wire logic               rx_req_valid,
	input  wire logic [7:0]         rx_req_tag,
	input  wire logic [9:0]         rx_req_len,
	output logic                    cpl_out_valid,
	output logic [7:0]              cpl_out_tag,
	output logic [9:0]              cpl_out_len,
	// outbound non-posted requests
	input  wire logic               req_valid,
	input  wire logic [9:0]         req_len,
	output logic                    req_ready,
	output logic [TAG_W-1:0]        req_tag,
	// inbound completions
	input  wire logic               cpl_in_valid,
	input  wire logic [TAG_W-1:0]   cpl_in_tag,
	input  wire logic [9:0]         cpl_in_len,
	output logic                    cpl_in_done,
	// detected errors from application logic
	input  wire pcie_err_pkg::err_vec_t det_err,
	input  wire logic               det_posted
);
	import pcie_err_pkg::*;

	typedef struct packed {
		logic [TAGS-1:0]       busy;
		logic [TAGS-1:0][9:0]  remain;
		logic [TAG_W-1:0]      next_tag;
		logic [CRED_W-1:0]     free;
		err_vec_t              pend;
		err_vec_t              pend_post;
		err_vec_t              err;
		logic                  posted;
		logic                  wake;
		logic                  wake_done;
		logic                  wake_en;
		logic                  cpl_valid;
		logic [7:0]            cpl_tag;
		logic [9:0]            cpl_len;
		logic                  done;
		logic [7:0]            msg_code;
		logic [15:0]           msg_data;
		logic                  msg_rcvd;
		logic                  msg_new;
		logic [31:0]           rdata;
	} user_state_t;

	user_state_t s_q, s_d;

	function automatic logic [CRED_W-1:0] len_cred(input logic [9:0] l);
		return CRED_W'(l);
	endfunction : len_cred

	assign req_ready = ~s_q.busy[s_q.next_tag] &
	                   (s_q.free >= len_cred(req_len));

	always_comb begin
		err_vec_t new_err;
		err_vec_t pick;
		logic     new_post;
		logic     in_d0;
		logic     take;
		new_err  = '0;
		new_post = 1'b0;
		pick     = '0;
		in_d0    = (e.powerstate == `PWR_D0);
		take     = req_valid & req_ready;
		s_d      = s_q;
		s_d.cpl_valid = 1'b0;
		s_d.done      = 1'b0;
		s_d.wake      = 1'b0;
		s_d.err       = '0;
		s_d.posted    = 1'b0;

		if (rx_req_valid) begin
			s_d.cpl_valid = 1'b1;
			s_d.cpl_tag   = rx_req_tag;
			s_d.cpl_len   = rx_req_len;
		end

		if (take) begin
			s_d.busy[s_q.next_tag]   = 1'b1;
			s_d.remain[s_q.next_tag] = req_len;
			s_d.next_tag             = s_q.next_tag + TAG_W'(1);
		end

		if (cpl_in_valid & s_q.busy[cpl_in_tag]) begin
			if (s_q.remain[cpl_in_tag] <= cpl_in_len) begin
				s_d.busy[cpl_in_tag]   = 1'b0;
				s_d.remain[cpl_in_tag] = '0;
				s_d.done               = 1'b1;
			end else begin
				s_d.remain[cpl_in_tag] = s_q.remain[cpl_in_tag] -
				                         cpl_in_len;
			end
		end else if (cpl_in_valid) begin
			new_err[`ERR_CPL_UNEXP] = 1'b1;
		end

		// credit returns as data lands, taken back at issue
		s_d.free = s_q.free + (cpl_in_valid & s_q.busy[cpl_in_tag] ?
		           len_cred(cpl_in_len) : '0) -
		           (take ? len_cred(req_len) : '0);

		if (|det_err) begin
			new_err  = first_set(det_err);
			new_post = det_posted;
		end

		// register port
		if (reg_wr) begin
			unique case (reg_addr)
				`REG_CTRL: s_d.wake_en = reg_wdata[`CTRL_WAKE_EN];
				`REG_ERR: begin
					if (|det_err == 1'b0) begin
						new_err  = first_set(reg_wdata[`ERR_W-1:0]);
						new_post = reg_wdata[`ERR_POSTED_BIT];
					end
				end
				default: ;
			endcase
		end

		s_d.pend      = s_q.pend | new_err;
		s_d.pend_post = (s_q.pend_post & ~new_err) |
		                (new_post ? new_err : '0);

		if (in_d0 & (|s_q.pend)) begin
			pick = first_set(s_q.pend);
			s_d.err    = pick;
			s_d.posted = |(pick & s_q.pend_post);
			// set wins over clear of the same bit
			s_d.pend   = (s_q.pend & ~pick) | new_err;
		end

		if (in_d0) begin
			s_d.wake_done = 1'b0;
		end else if ((|s_q.pend) & e.pme_en & s_q.wake_en &
		             ~s_q.wake_done) begin
			s_d.wake      = 1'b1;
			s_d.wake_done = 1'b1;
		end

		// notification bus capture, new flag cleared by read
		if (reg_rd & (reg_addr == `REG_MSG))
			s_d.msg_new = 1'b0;
		if (e.msg_valid) begin
			s_d.msg_code = e.msg_code;
			s_d.msg_data = e.msg_data;
			s_d.msg_rcvd = e.msg_received;
			s_d.msg_new  = 1'b1;
		end

		// read data valid only in the cycle after the strobe
		s_d.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				`REG_CTRL: s_d.rdata[`CTRL_WAKE_EN] = s_q.wake_en;
				`REG_STAT: begin
					s_d.rdata[`ERR_W-1:0] = s_q.pend;
					s_d.rdata[`STAT_PWR_LSB +: 2] = e.powerstate;
					s_d.rdata[`STAT_PME_BIT] = e.pme_en;
					s_d.rdata[`STAT_FREE_LSB +: 16] = 16'(s_q.free);
				end
				`REG_MSG: begin
					s_d.rdata[7:0] = s_q.msg_code;
					s_d.rdata[`MSG_DATA_LSB +: 16] = s_q.msg_data;
					s_d.rdata[`MSG_RCVD_BIT] = s_q.msg_rcvd;
					s_d.rdata[`MSG_NEW_BIT] = s_q.msg_new;
				end
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q      <= '0;
			s_q.free <= CRED_W'(CPL_SPACE);
		end else begin
			s_q <= s_d;
		end
	end

	assign e.err                = s_q.err;
	assign e.err_posted         = s_q.posted;
	assign e.wake_request_pulse = s_q.wake;
	assign cpl_out_valid        = s_q.cpl_valid;
	assign cpl_out_tag          = s_q.cpl_tag;
	assign cpl_out_len          = s_q.cpl_len;
	assign cpl_in_done          = s_q.done;
	assign req_tag              = s_q.next_tag;
	assign reg_rdata            = s_q.rdata;

endmodule : pcie_err_user

`default_nettype wire

// ---- sim/pcie_err_asserts.sv ----
// concurrent checks on the error link between the two ends
`timescale 1ns/1ps
`default_nettype none
`include "pcie_err_map.svh"

module pcie_err_asserts (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   resetn,
	// error link signals
	input wire pcie_err_pkg::err_vec_t err,
	input wire logic                   wake_request_pulse,
	input wire logic [1:0]             powerstate,
	input wire logic                   pme_en,
	input wire logic                   msg_valid,
	input wire logic                   msg_received
);
	import pcie_err_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// named steps
	// ----------------------------------------
	sequence out_of_d0;
		powerstate != `PWR_D0;
	endsequence

	// wake is launched from the previous cycle's state
	sequence asleep_armed;
		$past(pme_en) && ($past(powerstate) != `PWR_D0);
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_err_onehot: assert property (
		err != '0 |-> $onehot(err))
		else $error("several error indications in one cycle");
	chk_err_in_d0: assert property (
		err != '0 |-> $past(powerstate) == `PWR_D0)
		else $error("error indication outside full power");
	chk_quiet_asleep: assert property (
		out_of_d0 ##1 out_of_d0 |-> err == '0)
		else $error("error not held while asleep");
	chk_err_single: assert property (
		err != '0 |=> (err & $past(err)) == '0)
		else $error("error indication longer than one cycle");
	chk_wake_cause: assert property (
		wake_request_pulse |-> asleep_armed)
		else $error("wake request without pme enable");
	chk_wake_once: assert property (
		wake_request_pulse |=> (!wake_request_pulse) [*4])
		else $error("wake request repeated");
	chk_msg_flag: assert property (
		msg_valid |-> msg_received)
		else $error("received message not flagged");
	chk_msg_pulse: assert property (
		msg_valid |=> !msg_valid)
		else $error("message notice longer than one cycle");

endmodule : pcie_err_asserts

`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for both ends of the error link
`timescale 1ns/1ps
`default_nettype none
`include "pcie_err_map.svh"

`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
	bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end

module tb_top;
	import pcie_err_pkg::*;

	localparam int EP = 0, CPL = 1, MSG = 2, WAKE = 3, MV = 4;
	localparam int RCV = 5, STR = 6, DONE = 7, OUT = 8;
	localparam int LOC = 9, RTX = 10, RRCV = 11, RSTR = 12;
	logic        rp_tx, rp_str, pme_status;
	logic        clk = 0, resetn = 0, pme_enable = 0, aer_en = 0;
	logic        cor_en = 0, nf_en = 0, fatal_en = 0, serr_en = 0;
	logic        rx_msg_valid = 0, int_err_valid = 0, reg_wr = 0, reg_rd = 0;
	logic        rx_req_valid = 0, req_valid = 0, cpl_in_valid = 0;
	logic        det_posted = 0, tx_cpl_valid, tx_msg_valid;
	logic        stream_msg_valid, cpl_out_valid, req_ready, cpl_in_done;
	logic [1:0]  pwr_state = 0;
	logic [3:0]  reg_addr = 0;
	logic [4:0]  req_tag, cpl_in_tag = 0, tg;
	logic [7:0]  rx_msg_code = 0, rx_req_tag = 0, cpl_out_tag, otag, lc;
	logic [9:0]  rx_req_len = 0, req_len = 0, cpl_in_len = 0;
	logic [9:0]  cpl_out_len, olen;
	logic [15:0] rx_msg_data = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, rv;
	err_vec_t    aer_mask = 0, aer_sev = 0, status_clr = 0, det_err = 0;
	err_vec_t    err_status, seen;
	msg_kind_t   int_err_kind = MSG_COR, tx_msg_kind, mk;
	cpl_status_t tx_cpl_status, cst;
	int          bad_count = 0, n_tests = 0, cyc = 0, n[13];

	// ----------------------------------------
	// the two ends and the checker
	// ----------------------------------------
	pcie_err_if lnk ();
	pcie_err_core u_pcie_err_core (.clk, .resetn, .e(lnk), .pwr_state,
		.pme_enable, .aer_en, .cor_en, .nf_en, .fatal_en, .serr_en,
		.aer_mask, .aer_sev, .status_clr, .rx_msg_valid, .rx_msg_code,
		.rx_msg_data, .int_err_valid, .int_err_kind, .tx_cpl_valid,
		.tx_cpl_status, .tx_msg_valid, .tx_msg_kind, .stream_msg_valid,
		.stream_msg_code(), .err_status, .pme_status);
	// root-port pair: errors stay local, messages also on stream
	pcie_err_if rp ();
	pcie_err_core #(.FORWARD_MSGS(1'b1), .ROOT_PORT(1'b1))
		u_pcie_err_core_rp (.clk, .resetn, .e(rp), .pwr_state,
		.pme_enable, .aer_en, .cor_en, .nf_en, .fatal_en, .serr_en,
		.aer_mask, .aer_sev, .status_clr, .rx_msg_valid, .rx_msg_code,
		.rx_msg_data, .int_err_valid, .int_err_kind, .tx_cpl_valid(),
		.tx_cpl_status(), .tx_msg_valid(rp_tx), .tx_msg_kind(),
		.stream_msg_valid(rp_str), .stream_msg_code(), .err_status(),
		.pme_status());
	pcie_err_user u_pcie_err_user_rp (.clk, .resetn, .e(rp), .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .rx_req_valid,
		.rx_req_tag, .rx_req_len, .cpl_out_valid(), .cpl_out_tag(),
		.cpl_out_len(), .req_valid, .req_len, .req_ready(), .req_tag(),
		.cpl_in_valid, .cpl_in_tag, .cpl_in_len, .cpl_in_done(),
		.det_err, .det_posted);
	// small completion space so the refusal is reachable
	pcie_err_user #(.CPL_SPACE(8)) u_pcie_err_user (.clk, .resetn,
		.e(lnk), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_req_valid, .rx_req_tag, .rx_req_len, .cpl_out_valid,
		.cpl_out_tag, .cpl_out_len, .req_valid, .req_len, .req_ready,
		.req_tag, .cpl_in_valid, .cpl_in_tag, .cpl_in_len, .cpl_in_done,
		.det_err, .det_posted);
	pcie_err_asserts u_pcie_err_asserts (.clk, .resetn, .err(lnk.err),
		.wake_request_pulse(lnk.wake_request_pulse),
		.powerstate(lnk.powerstate), .pme_en(lnk.pme_en),
		.msg_valid(lnk.msg_valid), .msg_received(lnk.msg_received));

	always #5 clk = ~clk;

	// ----------------------------------------
	// event counters, sampled at the edge
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			report_and_stop();
		end
		if (|lnk.err) begin
			seen |= lnk.err;
			n[EP]++;
		end
		if (tx_cpl_valid) begin
			n[CPL]++;
			cst = tx_cpl_status;
		end
		if (tx_msg_valid) begin
			n[MSG]++;
			mk = tx_msg_kind;
		end
		if (cpl_out_valid) begin
			n[OUT]++;
			otag = cpl_out_tag;
			olen = cpl_out_len;
		end
		n[WAKE] += lnk.wake_request_pulse;
		n[MV] += lnk.msg_valid;
		n[RCV] += lnk.msg_valid & lnk.msg_received;
		n[STR] += stream_msg_valid;
		n[DONE] += cpl_in_done;
		n[RTX] += rp_tx;
		n[RSTR] += rp_str;
		n[RRCV] += rp.msg_valid & rp.msg_received;
		if (rp.msg_valid & !rp.msg_received) begin
			n[LOC]++;
			lc = rp.msg_code;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function automatic err_vec_t eb(input int i);
		return err_vec_t'(1) << i;
	endfunction : eb

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task clr();
		seen = '0;
		n = '{default: 0};
	endtask : clr

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd

	task rep(input err_vec_t v, input logic p);
		clr();
		@(posedge clk);
		det_err <= v;
		det_posted <= p;
		@(posedge clk);
		det_err <= '0;
		det_posted <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
	endtask : rep

	task sleep(input logic pme, input int wakes);
		@(posedge clk);
		pwr_state <= 2'h3;
		pme_enable <= pme;
		rep(eb(`ERR_UR), 1'b1);
		`CHK("held err", 12'h0, seen)
		`CHK("wakes", wakes, n[WAKE])
		clr();
		@(posedge clk);
		pwr_state <= `PWR_D0;
		repeat (4) @(posedge clk);
		#1;
		`CHK("late err", eb(`ERR_UR), seen)
	endtask : sleep

	task piece(input logic [9:0] len);
		@(posedge clk);
		cpl_in_valid <= 1'b1;
		cpl_in_tag <= tg;
		cpl_in_len <= len;
		@(posedge clk);
		cpl_in_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : piece

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd(`REG_STAT);
		`CHK("free", 16'h0008, rv[31:16])
		wr(`REG_CTRL, 32'h1);
		@(posedge clk);
		aer_en <= 1'b1;
		cor_en <= 1'b1;
		rep(eb(`ERR_UR), 1'b0);
		`CHK("ur err", eb(`ERR_UR), seen)
		`CHK("ur cpl", 1, n[CPL])
		`CHK("ur status", CPL_UR, cst)
		`CHK("ur msg", MSG_COR, mk)
		`CHK("ur stat", 1'b1, err_status[`ERR_UR])
		`CHK("root tx", 0, n[RTX])
		`CHK("root local", 1, n[LOC])
		`CHK("root code", `MSG_CODE_COR, lc)
		@(posedge clk);
		aer_mask <= eb(`ERR_UR);
		rep(eb(`ERR_UR), 1'b0);
		`CHK("masked msg", 0, n[MSG])
		@(posedge clk);
		aer_mask <= '0;
		status_clr <= eb(`ERR_UR);
		@(posedge clk);
		status_clr <= '0;
		aer_en <= 1'b0;
		nf_en <= 1'b1;
		#1 `CHK("cleared", 1'b0, err_status[`ERR_UR])
		rep(eb(`ERR_UR), 1'b1);
		`CHK("posted cpl", 0, n[CPL])
		`CHK("posted msg", MSG_NONFATAL, mk)
		`CHK("posted stat", 1'b1, err_status[`ERR_UR])
		@(posedge clk);
		nf_en <= 1'b0;
		rep(eb(`ERR_UR), 1'b1);
		`CHK("disabled msg", 0, n[MSG])
		rep(eb(`ERR_CPL_TO), 1'b0);
		`CHK("advisory", 0, n[CPL] + n[MSG])
		rep(eb(`ERR_CPL_ABORT), 1'b0);
		`CHK("abort cpl", CPL_CA, cst)
		rep(eb(`ERR_ECRC) | eb(`ERR_UR) | eb(`ERR_MALFORMED), 1'b1);
		`CHK("one of many", eb(`ERR_ECRC), seen)
		`CHK("one pulse", 1, n[EP])
		@(posedge clk);
		aer_en <= 1'b1;
		fatal_en <= 1'b1;
		aer_sev <= eb(`ERR_UR);
		rep(eb(`ERR_UR), 1'b1);
		`CHK("severity", MSG_FATAL, mk)
		clr();
		@(posedge clk);
		int_err_valid <= 1'b1;
		int_err_kind <= MSG_NONFATAL;
		@(posedge clk);
		int_err_valid <= 1'b0;
		aer_en <= 1'b0;
		fatal_en <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		`CHK("internal msg", MSG_NONFATAL, mk)
		`CHK("root internal", `MSG_CODE_NF, lc)
		`CHK("root no tx", 0, n[RTX])
		for (int i = 0; i < `ERR_W; i++) begin
			clr();
			wr(`REG_ERR, 32'(eb(i)) | (32'h1 << `ERR_POSTED_BIT));
			repeat (4) @(posedge clk);
			#1;
			`CHK("class", eb(i), seen)
		end
		sleep(1'b1, 1);
		`CHK("pme status", 1'b1, pme_status)
		sleep(1'b0, 0);
		clr();
		@(posedge clk);
		rx_msg_valid <= 1'b1;
		rx_msg_code <= 8'h20;
		rx_msg_data <= 16'h1234;
		@(posedge clk);
		rx_msg_valid <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("msg flagged", 1, n[RCV])
		`CHK("no stream", 0, n[STR])
		`CHK("root flagged", 1, n[RRCV])
		`CHK("root stream", 1, n[RSTR])
		rd(`REG_MSG);
		`CHK("msg reg", 32'h8112_3420, rv)
		@(posedge clk);
		req_valid <= 1'b1;
		req_len <= 10'h4;
		#1 tg = req_tag;
		`CHK("ready", 1'b1, req_ready)
		@(posedge clk);
		req_valid <= 1'b0;
		rd(`REG_STAT);
		`CHK("next tag", 5'h1, req_tag)
		`CHK("free left", 16'h0004, rv[31:16])
		@(posedge clk);
		req_valid <= 1'b1;
		req_len <= 10'h8;
		#1 `CHK("refused", 1'b0, req_ready)
		@(posedge clk);
		req_valid <= 1'b0;
		clr();
		for (int k = 0; k < 2; k++) begin
			piece(10'h2);
			`CHK("split done", k, n[DONE])
		end
		rd(`REG_STAT);
		`CHK("free back", 16'h0008, rv[31:16])
		clr();
		piece(10'h2);
		`CHK("idle tag", eb(`ERR_CPL_UNEXP), seen)
		clr();
		@(posedge clk);
		rx_req_valid <= 1'b1;
		rx_req_tag <= 8'h5A;
		rx_req_len <= 10'h10;
		@(posedge clk);
		rx_req_valid <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("cpl out", 1, n[OUT])
		`CHK("cpl tag", 8'h5A, otag)
		`CHK("cpl len", 10'h10, olen)
		report_and_stop();
	end

endmodule : tb_top

`default_nettype wire
